/* core/interrupt_control_unit.sv */
// Interrupt control unit: enables, external edge flag, vectoring,
// shadow context save and restore, wake from Sleep.
// Assumes a core that drives a one-cycle Q1 strobe per instruction
// cycle and that all inputs are synchronous to ref_clk_i.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "interrupt_control_unit_defs.svh"

module interrupt_control_unit #(
    parameter int PIN_COUNT = 8
) (
    input  wire logic                                 ref_clk_i,
    input  wire logic                                 rst_n_i,
    input  wire logic [`ADDR_W-1:0]                   addr_i,
    input  wire logic [7:0]                           wr_data_i,
    input  wire logic                                 wr_i,
    input  wire logic                                 rd_i,
    output logic      [7:0]                           rd_data_o,
    input  wire logic                                 q1_i,
    input  wire logic [PIN_COUNT-1:0]                 ext_pins_i,
    input  wire interrupt_control_unit_pkg::periph_flags_type flags_i,
    input  wire interrupt_control_unit_pkg::periph_flags_type clockless_i,
    input  wire logic                                 sleep_i,
    input  wire logic                                 post_sleep_done_i,
    input  wire logic                                 return_from_irq_instr_i,
    input  wire logic [`PC_W-1:0]                     pc_i,
    input  wire interrupt_control_unit_pkg::context_type live_ctx_i,
    output logic                                      irq_vector_o,
    output logic      [`PC_W-1:0]                     vector_pc_o,
    output logic                                      push_o,
    output logic      [`PC_W-1:0]                     push_pc_o,
    output logic                                      pop_o,
    output logic                                      restore_o,
    output interrupt_control_unit_pkg::context_type   restore_ctx_o,
    output logic                                      wake_o,
    output logic                                      global_irq_enable_o
);

    localparam int SEL_W = (PIN_COUNT > 1) ? $clog2(PIN_COUNT) : 1;

    // Refused at elaboration; the pin index must stay in range
    if (PIN_COUNT < 2 || PIN_COUNT > 64) begin
        $error("PIN_COUNT must lie between 2 and 64");
    end

    // Control and enable state
    logic                  global_irq_enable;
    logic                  periph_group_enable;
    logic                  ext_edge_select;
    logic                  ext_irq_enable;
    logic                  timer0_irq_enable;
    logic                  pin_change_irq_enable;
    logic [7:0]            sys_irq_enable;
    logic [7:0]            tmr_irq_enable;
    logic [SEL_W-1:0]      ext_irq_pin_select;
    logic                  ext_irq_flag;
    logic                  ext_pin_prev;
    logic                  edge_armed;
    interrupt_control_unit_pkg::context_type shadow;
    interrupt_control_unit_pkg::core_state_type state;
    interrupt_control_unit_pkg::core_state_type next_state;

    // Decoded strobes and combinational terms
    logic                  ext_pin;
    logic                  ext_edge;
    logic                  ext_now;
    logic                  vector_hit;
    logic                  wake_hit;
    logic                  take_irq;
    logic                  wr_ctrl;
    logic                  wr_status;

    // One source match; shared by vectoring and wake detection
    function automatic logic source_hit(
        input logic                                      ext_f,
        input interrupt_control_unit_pkg::periph_flags_type f,
        input logic                                      group_en,
        input logic                                      ext_en,
        input logic                                      t0_en,
        input logic                                      pc_en,
        input logic [7:0]                                sys_en,
        input logic [7:0]                                tmr_en
    );
        logic core_part;
        logic periph_part;
        core_part   = (ext_f & ext_en) | (f.timer0 & t0_en)
                    | (f.pin_change & pc_en);
        periph_part = (|(f.sys & sys_en))
                    | (|(f.tmr & tmr_en & `IRQ_EN_TMR_MASK));
        // Group enable only qualifies the later enable registers
        return core_part | (group_en & periph_part);
    endfunction

    assign ext_pin  = ext_pins_i[ext_irq_pin_select];
    // Retargeting the pin select can look like an edge; reset cannot
    assign ext_edge = edge_armed & (ext_edge_select
                                    ? (ext_pin & ~ext_pin_prev)
                                    : (~ext_pin & ext_pin_prev));
    // Edge in the Q1 cycle itself still counts for this sample
    assign ext_now  = ext_irq_flag | ext_edge;

    assign vector_hit = source_hit(ext_now, flags_i, periph_group_enable,
                                   ext_irq_enable, timer0_irq_enable,
                                   pin_change_irq_enable, sys_irq_enable,
                                   tmr_irq_enable);
    // Only the external edge and sources marked in clockless_i can wake
    assign wake_hit = source_hit(ext_now, flags_i & clockless_i,
                                 periph_group_enable, ext_irq_enable,
                                 timer0_irq_enable & clockless_i.timer0,
                                 pin_change_irq_enable
                                     & clockless_i.pin_change,
                                 sys_irq_enable, tmr_irq_enable);

    // Sampled at Q1 only; blocked while the post-sleep instruction runs
    assign take_irq = q1_i & (state == interrupt_control_unit_pkg::ST_RUN)
                    & global_irq_enable & vector_hit
                    & ~irq_vector_o;

    assign wr_ctrl   = wr_i && (addr_i == `ADDR_INTERRUPT_CTRL);
    assign wr_status = wr_i && (addr_i == `ADDR_EXT_STATUS);

    // Sleep and wake sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            interrupt_control_unit_pkg::ST_RUN: begin
                if (sleep_i && !take_irq) begin
                    next_state = interrupt_control_unit_pkg::ST_SLEEP;
                end
            end
            interrupt_control_unit_pkg::ST_SLEEP: begin
                if (wake_hit) begin
                    next_state = interrupt_control_unit_pkg::ST_WAKE;
                end
            end
            interrupt_control_unit_pkg::ST_WAKE: begin
                if (post_sleep_done_i) begin
                    next_state = interrupt_control_unit_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = interrupt_control_unit_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state  <= interrupt_control_unit_pkg::ST_RUN;
            wake_o <= 1'h0;
        end else begin
            state  <= next_state;
            // Wake never vectors by itself; the run state decides
            wake_o <= (state == interrupt_control_unit_pkg::ST_SLEEP)
                      && wake_hit;
        end
    end

    // Interrupt control register; hardware events beat software writes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_irq_enable   <= 1'h0;
            periph_group_enable <= 1'h0;
            ext_edge_select     <= `EDGE_SEL_RESET;
        end else begin
            if (wr_ctrl) begin
                global_irq_enable   <= wr_data_i[`BIT_GLOBAL_EN];
                periph_group_enable <= wr_data_i[`BIT_PERIPH_EN];
                ext_edge_select     <= wr_data_i[`BIT_EDGE_SEL];
            end
            if (take_irq) begin
                global_irq_enable <= 1'h0;
            end else if (return_from_irq_instr_i) begin
                global_irq_enable <= 1'h1;
            end
        end
    end

    // Per-source enable registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_enable        <= 1'h0;
            timer0_irq_enable     <= 1'h0;
            pin_change_irq_enable <= 1'h0;
            sys_irq_enable        <= 8'h00;
            tmr_irq_enable        <= 8'h00;
            ext_irq_pin_select    <= '0;
        end else if (wr_i) begin
            unique case (addr_i)
                `ADDR_IRQ_EN_CORE: begin
                    timer0_irq_enable     <= wr_data_i[`BIT_TIMER0_EN];
                    pin_change_irq_enable <= wr_data_i[`BIT_PIN_CHANGE_EN];
                    ext_irq_enable        <= wr_data_i[`BIT_EXT_EN];
                end
                `ADDR_IRQ_EN_SYS: begin
                    sys_irq_enable <= wr_data_i;
                end
                `ADDR_IRQ_EN_TMR: begin
                    tmr_irq_enable <= wr_data_i & `IRQ_EN_TMR_MASK;
                end
                `ADDR_EXT_PIN_SEL: begin
                    ext_irq_pin_select <= wr_data_i[SEL_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // External edge flag; an edge in the clearing cycle survives
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_pin_prev <= 1'h0;
            edge_armed   <= 1'h0;
            ext_irq_flag <= 1'h0;
        end else begin
            ext_pin_prev <= ext_pin;
            edge_armed   <= 1'h1;
            if (ext_edge) begin
                ext_irq_flag <= 1'h1;
            end else if (wr_status && !wr_data_i[`BIT_EXT_FLAG]) begin
                ext_irq_flag <= 1'h0;
            end
        end
    end

    // Entry and return sequencing toward the core
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_vector_o  <= 1'h0;
            vector_pc_o   <= `VECTOR_ADDR;
            push_o        <= 1'h0;
            push_pc_o     <= '0;
            pop_o         <= 1'h0;
            restore_o     <= 1'h0;
            restore_ctx_o <= '0;
        end else begin
            // Fixed one-cycle step keeps latency instruction independent
            irq_vector_o <= take_irq;
            vector_pc_o  <= `VECTOR_ADDR;
            push_o       <= take_irq;
            if (take_irq) begin
                push_pc_o <= pc_i;
            end
            pop_o     <= return_from_irq_instr_i;
            restore_o <= return_from_irq_instr_i;
            if (return_from_irq_instr_i) begin
                restore_ctx_o <= shadow;
            end
        end
    end

    // Shadow copies; capture on entry wins over a software write
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shadow <= '0;
        end else if (take_irq) begin
            shadow        <= live_ctx_i;
            // Watchdog and power-down bits are never saved
            shadow.status <= live_ctx_i.status & `STATUS_SAVE_MASK;
        end else if (wr_i) begin
            unique case (addr_i)
                `ADDR_SHAD_STATUS: begin
                    shadow.status <= wr_data_i & `STATUS_SAVE_MASK;
                end
                `ADDR_SHAD_WORK: begin
                    shadow.working <= wr_data_i;
                end
                `ADDR_SHAD_BANK: begin
                    shadow.bank <= wr_data_i[`BANK_W-1:0];
                end
                `ADDR_SHAD_PCHI: begin
                    shadow.pc_high <= wr_data_i[`PCHI_W-1:0];
                end
                `ADDR_SHAD_PTR0_LO: begin
                    shadow.ptr0[7:0] <= wr_data_i;
                end
                `ADDR_SHAD_PTR0_HI: begin
                    shadow.ptr0[15:8] <= wr_data_i;
                end
                `ADDR_SHAD_PTR1_LO: begin
                    shadow.ptr1[7:0] <= wr_data_i;
                end
                `ADDR_SHAD_PTR1_HI: begin
                    shadow.ptr1[15:8] <= wr_data_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Read port: data registered, valid in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                `ADDR_INTERRUPT_CTRL: begin
                    rd_data_o <= {global_irq_enable, periph_group_enable,
                                  5'h00, ext_edge_select};
                end
                `ADDR_IRQ_EN_CORE: begin
                    rd_data_o <= {2'h0, timer0_irq_enable,
                                  pin_change_irq_enable, 3'h0,
                                  ext_irq_enable};
                end
                `ADDR_IRQ_EN_SYS:   rd_data_o <= sys_irq_enable;
                `ADDR_IRQ_EN_TMR:   rd_data_o <= tmr_irq_enable;
                `ADDR_EXT_STATUS:   rd_data_o <= {7'h00, ext_irq_flag};
                `ADDR_EXT_PIN_SEL:  rd_data_o <= 8'(ext_irq_pin_select);
                `ADDR_SHAD_STATUS:  rd_data_o <= shadow.status;
                `ADDR_SHAD_WORK:    rd_data_o <= shadow.working;
                `ADDR_SHAD_BANK:    rd_data_o <= 8'(shadow.bank);
                `ADDR_SHAD_PCHI:    rd_data_o <= 8'(shadow.pc_high);
                `ADDR_SHAD_PTR0_LO: rd_data_o <= shadow.ptr0[7:0];
                `ADDR_SHAD_PTR0_HI: rd_data_o <= shadow.ptr0[15:8];
                `ADDR_SHAD_PTR1_LO: rd_data_o <= shadow.ptr1[7:0];
                `ADDR_SHAD_PTR1_HI: rd_data_o <= shadow.ptr1[15:8];
                default:            rd_data_o <= 8'h00;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // Mirror for the core's own use of the global enable
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_irq_enable_o <= 1'h0;
        end else begin
            global_irq_enable_o <= global_irq_enable;
        end
    end

endmodule

/* core/interrupt_control_unit_defs.svh */
// Constants of the interrupt control unit: offsets, bit positions,
// reset values, masks and widths.
// Assumes inclusion by bare name from design and bench files.
`ifndef INTERRUPT_CONTROL_UNIT_DEFS_SVH
`define INTERRUPT_CONTROL_UNIT_DEFS_SVH

`define ADDR_W              13
`define ADDR_INTERRUPT_CTRL 13'h000b
`define ADDR_IRQ_EN_CORE    13'h0096
`define ADDR_IRQ_EN_SYS     13'h0097
`define ADDR_IRQ_EN_TMR     13'h0098
`define ADDR_EXT_STATUS     13'h008c
`define ADDR_EXT_PIN_SEL    13'h0090
`define ADDR_SHAD_STATUS    13'h1fe4
`define ADDR_SHAD_WORK      13'h1fe5
`define ADDR_SHAD_BANK      13'h1fe6
`define ADDR_SHAD_PCHI      13'h1fe7
`define ADDR_SHAD_PTR0_LO   13'h1fe8
`define ADDR_SHAD_PTR0_HI   13'h1fe9
`define ADDR_SHAD_PTR1_LO   13'h1fea
`define ADDR_SHAD_PTR1_HI   13'h1feb

`define BIT_GLOBAL_EN       7
`define BIT_PERIPH_EN       6
`define BIT_EDGE_SEL        0
`define BIT_TIMER0_EN       5
`define BIT_PIN_CHANGE_EN   4
`define BIT_EXT_EN          0
`define BIT_EXT_FLAG        0
`define BIT_WATCHDOG        4
`define BIT_POWERDOWN       3

`define EDGE_SEL_RESET      1'h1
`define IRQ_EN_TMR_MASK     8'h6f
`define STATUS_SAVE_MASK    8'he7
`define VECTOR_ADDR         15'h0004

`define PC_W                15
`define BANK_W              6
`define PCHI_W              7

`endif

/* core/interrupt_control_unit_pkg.sv */
// Types of the interrupt control unit.
// Assumes the constants header is compiled alongside.
`include "interrupt_control_unit_defs.svh"

package interrupt_control_unit_pkg;

    typedef struct packed {
        logic [7:0]              status;
        logic [7:0]              working;
        logic [`BANK_W-1:0]      bank;
        logic [`PCHI_W-1:0]      pc_high;
        logic [15:0]             ptr0;
        logic [15:0]             ptr1;
    } context_type;

    typedef struct packed {
        logic                    timer0;
        logic                    pin_change;
        logic [7:0]              sys;
        logic [7:0]              tmr;
    } periph_flags_type;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE  = 2'h3
    } core_state_type;

endpackage

/* tb/icu_core_model.sv */
// Core stand-in: one Q1 strobe every four clocks and a running PC.
// Assumes the clock and reset of the unit under test.
`timescale 1ns/100ps
module icu_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    output logic             q1_o,
    output logic [14:0]      pc_o
);
    logic [1:0] phase;

    // Four clocks to an instruction cycle, Q1 first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= 2'h0;
            pc_o  <= 15'h0100;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                pc_o <= pc_o + 15'h0001;
            end
        end
    end
    // Gated by reset so no strobe is seen before release
    assign q1_o = (phase == 2'h0) && rst_n_i;
endmodule

/* tb/interrupt_control_unit_checker.sv */
// Port checks of the interrupt control unit.
// Assumes it is bound onto every instance of the unit.
`timescale 1ns/100ps
`include "interrupt_control_unit_defs.svh"
module interrupt_control_unit_checker (
    input wire logic             ref_clk_i,
    input wire logic             rst_n_i,
    input wire logic             q1_i,
    input wire logic             sleep_i,
    input wire logic             return_from_irq_instr_i,
    input wire logic [`PC_W-1:0] pc_i,
    input wire logic             irq_vector_o,
    input wire logic [`PC_W-1:0] vector_pc_o,
    input wire logic             push_o,
    input wire logic [`PC_W-1:0] push_pc_o,
    input wire logic             pop_o,
    input wire logic             restore_o,
    input wire logic             wake_o,
    input wire logic             global_irq_enable_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_vector_after_q1:
        assert property (irq_vector_o |-> $past(q1_i))
        else $error("vector without a Q1 sample");
    a_vector_fixed_addr:
        assert property (vector_pc_o == `VECTOR_ADDR)
        else $error("vector address wrong");
    a_push_with_vector:
        assert property (push_o == irq_vector_o)
        else $error("push and vector apart");
    a_push_pc_taken:
        assert property (push_o |-> push_pc_o == $past(pc_i))
        else $error("pushed address wrong");
    a_vector_needs_global:
        assert property (irq_vector_o |-> global_irq_enable_o)
        else $error("vector with global enable clear");
    a_entry_clears_global:
        assert property (irq_vector_o |=> !global_irq_enable_o)
        else $error("global enable kept on entry");
    a_vector_one_pulse:
        assert property (irq_vector_o |=> !irq_vector_o)
        else $error("vector pulse too long");
    a_return_restores:
        assert property (return_from_irq_instr_i |=> pop_o && restore_o)
        else $error("return without pop and restore");
    a_return_sets_global:
        assert property (return_from_irq_instr_i |-> ##2 global_irq_enable_o)
        else $error("global enable not set by return");
    a_wake_from_sleep:
        assert property (wake_o |-> $past(sleep_i))
        else $error("wake outside sleep");
endmodule

bind interrupt_control_unit interrupt_control_unit_checker chk_i (
    .ref_clk_i, .rst_n_i, .q1_i, .sleep_i, .return_from_irq_instr_i,
    .pc_i, .irq_vector_o, .vector_pc_o, .push_o, .push_pc_o, .pop_o,
    .restore_o, .wake_o, .global_irq_enable_o
);

/* tb/interrupt_control_unit_tb.sv */
// Self-checking bench of the interrupt control unit.
// Assumes the core model and the bound checker are compiled with it.
`timescale 1ns/100ps
module interrupt_control_unit_tb;
    logic        ref_clk_i, rst_n_i, wr, rd, q1, sleep, psd, ret;
    logic        vec, wake, ge;
    logic [7:0]  wdat, rdat, pins;
    logic [12:0] addr;
    logic [14:0] pc;
    int          error_cnt = 0, compares = 0, nvec = 0, nwake = 0, cyc = 0;
    logic [7:0]  msk [3] = '{8'h31, 8'hff, 8'h6f};
    interrupt_control_unit_pkg::periph_flags_type flags, cless;
    interrupt_control_unit_pkg::context_type      live, rctx;

    icu_core_model icu_core_model_i (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .q1_o(q1), .pc_o(pc));
    interrupt_control_unit interrupt_control_unit_i (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdat), .q1_i(q1), .ext_pins_i(pins),
        .flags_i(flags), .clockless_i(cless), .sleep_i(sleep),
        .post_sleep_done_i(psd), .return_from_irq_instr_i(ret), .pc_i(pc),
        .live_ctx_i(live), .irq_vector_o(vec), .vector_pc_o(), .push_o(),
        .push_pc_o(), .pop_o(), .restore_o(), .restore_ctx_o(rctx),
        .wake_o(wake), .global_irq_enable_o(ge));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdat <= d;
        wr   <= 1'h1;
        @(posedge ref_clk_i);
        wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'h1;
        @(posedge ref_clk_i);
        rd <= 1'h0;
        #1;
        cmp({8'h00, rdat}, {8'h00, e});
    endtask
    // Stale flag is cleared after each look so later tests start clean
    task automatic edge_chk(input logic v, input logic [7:0] e);
        @(posedge ref_clk_i);
        pins[1] <= v;
        wait_cyc(2);
        rd_chk(13'h008c, e);
        wr_reg(13'h008c, 8'h00);
    endtask
    task automatic pulse_ret;
        @(posedge ref_clk_i);
        ret <= 1'h1;
        @(posedge ref_clk_i);
        ret <= 1'h0;
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'h0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Event counts and the hang limit
    always @(posedge ref_clk_i) begin
        nvec += (vec === 1'h1);
        nwake += (wake === 1'h1);
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        {rst_n_i, wr, rd, sleep, psd, ret} = 6'h00;
        addr = 13'h0000;
        wdat = 8'h00;
        pins = 8'h00;
        flags = '0;
        cless = '0;
        cless.tmr[0] = 1'h1;
        live = '{8'hff, 8'h11, 6'h2a, 7'h33, 16'h1234, 16'h5678};
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        rd_chk(13'h000b, 8'h01);
        for (int i = 0; i < 3; i++) begin
            rd_chk(13'h0096 + 13'(i), 8'h00);
            wr_reg(13'h0096 + 13'(i), 8'hff);
            rd_chk(13'h0096 + 13'(i), msk[i]);
            wr_reg(13'h0096 + 13'(i), 8'h00);
        end
        rd_chk(13'h0000, 8'h00);
        $display("registers done");
        wr_reg(13'h0090, 8'h01);
        wr_reg(13'h008c, 8'h00);
        @(posedge ref_clk_i);
        pins[0] <= 1'h1;
        wait_cyc(2);
        rd_chk(13'h008c, 8'h00);
        edge_chk(1'h1, 8'h01);
        edge_chk(1'h0, 8'h00);
        wr_reg(13'h000b, 8'h00);
        edge_chk(1'h1, 8'h00);
        edge_chk(1'h0, 8'h01);
        cmp(16'(nvec), 16'h0000);
        $display("edges done");
        wr_reg(13'h0096, 8'h01); // flag already clear
        wr_reg(13'h000b, 8'h81);
        @(posedge ref_clk_i);
        pins[1] <= 1'h1;
        wait_cyc(8);
        cmp(16'(nvec), 16'h0001);
        rd_chk(13'h1fe4, 8'he7);
        rd_chk(13'h1fe9, 8'h12);
        wr_reg(13'h1fe5, 8'h5a);
        live.working <= 8'h99;
        wr_reg(13'h008c, 8'h00);
        pulse_ret();
        #1;
        cmp({rctx.working, rctx.status}, 16'h5ae7);
        wait_cyc(1);
        cmp({15'h0000, ge}, 16'h0001);
        $display("entry and return done");
        wr_reg(13'h0096, 8'h00);
        wr_reg(13'h0097, 8'h01);
        @(posedge ref_clk_i);
        flags.sys[0] <= 1'h1;
        wait_cyc(8);
        cmp(16'(nvec), 16'h0001);
        wr_reg(13'h000b, 8'hc1);
        wait_cyc(8);
        cmp(16'(nvec), 16'h0002);
        @(posedge ref_clk_i);
        flags.sys[0] <= 1'h0;
        pulse_ret();
        wr_reg(13'h0097, 8'h00);
        wr_reg(13'h000b, 8'h81);
        wr_reg(13'h0096, 8'h20);
        @(posedge ref_clk_i);
        flags.timer0 <= 1'h1;
        wait_cyc(8);
        cmp(16'(nvec), 16'h0003);
        @(posedge ref_clk_i);
        flags.timer0 <= 1'h0;
        pulse_ret();
        $display("group enable done");
        wr_reg(13'h0096, 8'h00);
        wr_reg(13'h0098, 8'h03); // wake sources enabled first
        wr_reg(13'h000b, 8'hc1);
        @(posedge ref_clk_i);
        sleep <= 1'h1;
        @(posedge ref_clk_i);
        flags.tmr[1] <= 1'h1;
        wait_cyc(8);
        cmp(16'(nwake), 16'h0000);
        @(posedge ref_clk_i);
        flags.tmr <= 8'h01;
        wait_cyc(4);
        cmp(16'(nwake), 16'h0001);
        @(posedge ref_clk_i);
        sleep <= 1'h0;
        wait_cyc(8);
        cmp(16'(nvec), 16'h0003);
        @(posedge ref_clk_i);
        psd <= 1'h1;
        @(posedge ref_clk_i);
        psd <= 1'h0;
        wait_cyc(6);
        cmp(16'(nvec), 16'h0004);
        @(posedge ref_clk_i);
        flags.tmr <= 8'h00;
        pulse_ret();
        $display("sleep done");
        test_done();
    end
endmodule
